// ==== logic/sdf_cfg_decode.sv ====
// turns one filter configuration word into path, lengths and settling facts
`timescale 1ns/10ps
module sdf_cfg_decode import sdf_pkg::*; (
	input wire logic [CFG_W-1:0] cfg_in,
	output logic use_sinc3_out,
	output logic [LEN_W-1:0] avg_len_out,
	output logic [DEC_W-1:0] s3_dec_out,
	output logic single_cycle_out
);
	logic [LEN_W-1:0] rate_len;
	logic [CFG_RATE_W-1:0] rate_code;
	logic [CFG_ENH_W-1:0] enh_code;
	logic enh_on;

	assign rate_code = cfg_in[CFG_RATE_LSB +: CFG_RATE_W];
	assign enh_code = cfg_in[CFG_ENH_LSB +: CFG_ENH_W];
	assign rate_len = RATE_LEN[rate_code];
	// direct map overrides every other field and forces sinc3
	assign use_sinc3_out = cfg_in[CFG_MAP_BIT] | cfg_in[CFG_TYPE_BIT];
	// enhanced post-filter only rides on the combined path
	assign enh_on = cfg_in[CFG_ENH_EN_BIT] && !use_sinc3_out;
	assign avg_len_out = enh_on ? ENH_LEN[enh_code] : rate_len;
	// direct map: decimation = 32 x word[14:0], modulator-rate units
	assign s3_dec_out = cfg_in[CFG_MAP_BIT] ?
		DEC_W'({cfg_in[CFG_MAP_BIT-1:0], SINC3_DEC_UNIT_LOG2'(0)}) :
		DEC_W'({rate_len, SINC3_DEC_UNIT_LOG2'(0)});
	assign single_cycle_out = !use_sinc3_out && (avg_len_out >= SINGLE_CYCLE_LEN);
endmodule // sdf_cfg_decode

// ==== logic/sdf_cic.sv ====
// cascaded integrator-comb decimator with run-time decimation factor
`timescale 1ns/10ps
module sdf_cic import sdf_pkg::*; #(
	parameter int unsigned ORDER = 3,
	parameter int unsigned IN_W = 2,
	parameter int unsigned W = 64,
	parameter int unsigned DW = 20
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic clear_in,
	input wire logic valid_in,
	input wire logic signed [IN_W-1:0] data_in,
	input wire logic [DW-1:0] dec_in,
	output logic valid_out,
	output logic signed [W-1:0] data_out
);
	logic signed [W-1:0] integ_q [1:ORDER];
	logic signed [W-1:0] integ_in [0:ORDER-1];
	logic signed [W-1:0] comb [0:ORDER];
	logic signed [W-1:0] dly_q [0:ORDER-1];
	logic [DW-1:0] cnt_q;
	logic hit_q;
	logic signed [W-1:0] data_q;
	logic valid_q;

	// inputs are sparse, so the comb runs a cycle after the last integrate
	assign integ_in[0] = W'(data_in);
	assign comb[0] = integ_q[ORDER];
	genvar k;
	generate
		for (k = 0; k < ORDER; k++) begin : g_stage
			if (k > 0) begin : g_chain
				assign integ_in[k] = integ_q[k];
			end
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					integ_q[k+1] <= '0;
					dly_q[k] <= '0;
				end else if (clear_in) begin
					integ_q[k+1] <= '0;
					dly_q[k] <= '0;
				end else begin
					if (valid_in) begin
						integ_q[k+1] <= integ_q[k+1] + integ_in[k];
					end
					if (hit_q) begin
						dly_q[k] <= comb[k];
					end
				end
			end
			assign comb[k+1] = comb[k] - dly_q[k];
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= '0;
			hit_q <= 1'b0;
		end else if (clear_in) begin
			cnt_q <= '0;
			hit_q <= 1'b0;
		end else begin
			hit_q <= valid_in && (cnt_q >= dec_in - DW'(1));
			if (valid_in) begin
				cnt_q <= (cnt_q >= dec_in - DW'(1)) ? '0 : cnt_q + DW'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			valid_q <= 1'b0;
			data_q <= '0;
		end else begin
			valid_q <= hit_q && !clear_in;
			if (hit_q) begin
				data_q <= comb[ORDER];
			end
		end
	end

	assign valid_out = valid_q;
	assign data_out = data_q;
endmodule // sdf_cic

// ==== logic/sdf_filter.sv ====
// sigma-delta decimation filter chain with apb setup registers
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module sdf_filter import sdf_pkg::*; #(
	parameter int unsigned MCLK_HZ = MCLK_NOMINAL_HZ
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic MOD_BIT_IN,
	output logic MOD_TICK_OUT,
	input wire logic CONV_START_IN,
	input wire logic [SETUP_W-1:0] SETUP_SEL_IN,
	input wire logic MULTI_CHANNEL_IN,
	output logic DATA_READY_OUT,
	output logic [RESULT_W-1:0] RESULT_OUT,
	output logic [SETUP_W-1:0] RESULT_SETUP_OUT
);
	// modulator sample period in system clocks
	localparam int unsigned MOD_HZ = MCLK_HZ / MCLK_PER_MOD;
	localparam int unsigned MOD_DIV = SYS_CLK_HZ / MOD_HZ;
	localparam int unsigned DIV_W = $clog2(MOD_DIV + 1);

	logic [CFG_W-1:0] cfg_q [0:NUM_SETUPS-1];
	logic [31:0] mode_q;
	logic [DIV_W-1:0] div_q;
	logic mod_tick_q;
	conv_state_t state_q;
	conv_state_t state_d;
	logic [SETUP_W-1:0] setup_q;
	logic [CFG_W-1:0] act_cfg_q;
	logic [2:0] s5_skip_q;
	logic [2:0] s3_skip_q;
	logic clear_q;
	logic ready_q;
	logic [RESULT_W-1:0] result_q;
	logic [SETUP_W-1:0] result_setup_q;
	logic [15:0] count_q;
	logic use_sinc3;
	logic [LEN_W-1:0] avg_len;
	logic [DEC_W-1:0] s3_dec;
	logic single_cycle;
	logic settled_only;
	logic restart;
	logic signed [MOD_W-1:0] mod_val;
	logic s5_valid;
	logic signed [S5_W-1:0] s5_data;
	logic s1_valid;
	logic signed [S1_W-1:0] s1_data;
	logic s3_valid;
	logic signed [S3_W-1:0] s3_data;
	logic fin_valid;
	logic [RESULT_W-1:0] fin_data;
	logic deliver;
	logic apb_access;
	logic apb_write;
	logic addr_cfg;
	logic [SETUP_W-1:0] addr_idx;
	logic addr_ok;

	// modulator strobe at half the master clock
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			div_q <= '0;
			mod_tick_q <= 1'b0;
		end else begin
			mod_tick_q <= (div_q == DIV_W'(MOD_DIV - 1));
			div_q <= (div_q == DIV_W'(MOD_DIV - 1)) ? '0 : div_q + DIV_W'(1);
		end
	end

	assign MOD_TICK_OUT = mod_tick_q;
	assign mod_val = MOD_BIT_IN ? MOD_W'(1) : -MOD_W'(1);

	// apb slave, zero wait states
	assign apb_access = PSEL_IN && PENABLE_IN;
	assign apb_write = apb_access && PWRITE_IN;
	assign addr_cfg = (PADDR_IN >= FILTER_CONFIG_BASE) &&
		(PADDR_IN < FILTER_CONFIG_BASE + 8'(NUM_SETUPS * 4)) && (PADDR_IN[1:0] == 2'b00);
	assign addr_idx = SETUP_W'((PADDR_IN - FILTER_CONFIG_BASE) >> 2);
	assign addr_ok = addr_cfg || (PADDR_IN == MODE_CTRL_OFS) ||
		(PADDR_IN == FILTER_STATUS_OFS) || (PADDR_IN == RESULT_LO_OFS) ||
		(PADDR_IN == RESULT_HI_OFS);
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = apb_access && !addr_ok;

	always_comb begin
		PRDATA_OUT = '0;
		if (addr_cfg) begin
			PRDATA_OUT = 32'(cfg_q[addr_idx]);
		end else begin
			case (PADDR_IN)
				MODE_CTRL_OFS: PRDATA_OUT = mode_q;
				FILTER_STATUS_OFS: begin
					PRDATA_OUT[STAT_SETUP_LSB +: SETUP_W] = result_setup_q;
					PRDATA_OUT[STAT_SO_BIT] = settled_only;
					PRDATA_OUT[STAT_STATE_LSB +: 2] = state_q;
					PRDATA_OUT[STAT_COUNT_LSB +: 16] = count_q;
				end
				RESULT_LO_OFS: PRDATA_OUT = result_q[31:0];
				RESULT_HI_OFS: PRDATA_OUT = result_q[63:32];
				default: PRDATA_OUT = '0;
			endcase
		end
	end

	// one config word per setup
	genvar g;
	generate
		for (g = 0; g < NUM_SETUPS; g++) begin : g_cfg
			always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					cfg_q[g] <= FILTER_CONFIG_RST;
				end else if (apb_write && addr_cfg && addr_idx == SETUP_W'(g)) begin
					cfg_q[g] <= PWDATA_IN[CFG_W-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			mode_q <= MODE_CTRL_RST;
		end else if (apb_write && PADDR_IN == MODE_CTRL_OFS) begin
			mode_q <= {31'h0000_0000, PWDATA_IN[MODE_SETTLED_BIT]};
		end
	end

	// setup chosen at conversion start follows the channel
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			setup_q <= '0;
			act_cfg_q <= FILTER_CONFIG_RST;
		end else if (CONV_START_IN) begin
			setup_q <= SETUP_SEL_IN;
			act_cfg_q <= cfg_q[SETUP_SEL_IN];
		end
	end

	sdf_cfg_decode u_decode (
		.cfg_in(act_cfg_q),
		.use_sinc3_out(use_sinc3),
		.avg_len_out(avg_len),
		.s3_dec_out(s3_dec),
		.single_cycle_out(single_cycle)
	);

	// settled-only is void when already single cycle or scanning
	assign settled_only = mode_q[MODE_SETTLED_BIT] && !MULTI_CHANNEL_IN && !single_cycle;

	// sinc5 fixed at modulator/32 = 31.25 kSPS
	sdf_cic #(.ORDER(SINC5_ORDER), .IN_W(MOD_W), .W(S5_W), .DW(DEC_W)) u_sinc5 (
		.clk_in(CLK_SYS_IN),
		.rst_b_in(RST_B_IN),
		.clear_in(clear_q),
		.valid_in(mod_tick_q && !use_sinc3 && state_q != ST_IDLE),
		.data_in(mod_val),
		.dec_in(SINC5_DEC),
		.valid_out(s5_valid),
		.data_out(s5_data)
	);

	// sinc1 length alone sets the combined rate enhanced lengths ride here
	sdf_cic #(.ORDER(SINC1_ORDER), .IN_W(S5_W), .W(S1_W), .DW(LEN_W)) u_sinc1 (
		.clk_in(CLK_SYS_IN),
		.rst_b_in(RST_B_IN),
		.clear_in(clear_q),
		.valid_in(s5_valid && s5_skip_q == 3'h0),
		.data_in(s5_data),
		.dec_in(avg_len),
		.valid_out(s1_valid),
		.data_out(s1_data)
	);

	sdf_cic #(.ORDER(SINC3_ORDER), .IN_W(MOD_W), .W(S3_W), .DW(DEC_W)) u_sinc3 (
		.clk_in(CLK_SYS_IN),
		.rst_b_in(RST_B_IN),
		.clear_in(clear_q),
		.valid_in(mod_tick_q && use_sinc3 && state_q != ST_IDLE),
		.data_in(mod_val),
		.dec_in(s3_dec),
		.valid_out(s3_valid),
		.data_out(s3_data)
	);

	assign fin_valid = use_sinc3 ? s3_valid : s1_valid;
	assign fin_data = use_sinc3 ? RESULT_W'(s3_data) : RESULT_W'(s1_data);
	// sinc3 drops fill outputs only in settled-only mode
	// a start in the same cycle discards the result that was about to leave
	assign deliver = fin_valid && state_q == ST_RUN && !CONV_START_IN &&
		(!use_sinc3 || s3_skip_q == 3'h0);
	// settled-only restarts after each result so the next one is settled
	assign restart = CONV_START_IN || (deliver && settled_only);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (CONV_START_IN) begin
					state_d = ST_FILL;
				end
			end
			ST_FILL: state_d = ST_RUN;
			ST_RUN: begin
				if (restart) begin
					state_d = ST_FILL;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_q <= ST_IDLE;
			clear_q <= 1'b0;
		end else begin
			state_q <= state_d;
			clear_q <= restart;
		end
	end

	// sinc5 fill discarded after every restart so one cycle settles
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			s5_skip_q <= SINC5_FILL;
		end else if (restart) begin
			s5_skip_q <= SINC5_FILL;
		end else if (s5_valid && s5_skip_q != 3'h0) begin
			s5_skip_q <= s5_skip_q - 3'h1;
		end
	end

	// three sinc3 periods per settled result in settled-only mode
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			s3_skip_q <= '0;
		end else if (restart) begin
			s3_skip_q <= (mode_q[MODE_SETTLED_BIT] && !MULTI_CHANNEL_IN) ? SINC3_FILL : 3'h0;
		end else if (s3_valid && state_q == ST_RUN && s3_skip_q != 3'h0) begin
			s3_skip_q <= s3_skip_q - 3'h1;
		end
	end

	// result, setup index and ready pulse
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ready_q <= 1'b0;
			result_q <= '0;
			result_setup_q <= '0;
			count_q <= '0;
		end else begin
			ready_q <= deliver;
			if (deliver) begin
				result_q <= fin_data;
				result_setup_q <= setup_q;
				count_q <= count_q + 16'h0001;
			end
		end
	end

	assign DATA_READY_OUT = ready_q;
	assign RESULT_OUT = result_q;
	assign RESULT_SETUP_OUT = result_setup_q;
endmodule // sdf_filter

// ==== logic/sdf_pkg.sv ====
// constants, register map and rate tables for the decimation filter chain
package sdf_pkg;
	// clocks
	localparam int unsigned SYS_CLK_HZ = 125_000_000;
	localparam int unsigned MCLK_NOMINAL_HZ = 2_000_000;
	localparam int unsigned MCLK_PER_MOD = 2;
	localparam int unsigned SINC5_ORDER = 5;
	localparam int unsigned SINC3_ORDER = 3;
	localparam int unsigned SINC1_ORDER = 1;
	localparam logic [19:0] SINC5_DEC = 20'h0_0020;
	localparam int unsigned SINC3_DEC_UNIT_LOG2 = 5;
	// widths
	localparam int unsigned MOD_W = 2;
	localparam int unsigned S5_W = 27;
	localparam int unsigned S1_W = 40;
	localparam int unsigned S3_W = 64;
	localparam int unsigned RESULT_W = 64;
	localparam int unsigned LEN_W = 12;
	localparam int unsigned DEC_W = 20;
	localparam int unsigned NUM_SETUPS = 8;
	localparam int unsigned SETUP_W = 3;
	localparam int unsigned CFG_W = 16;
	// fill counts: sinc5 outputs dropped after a restart, sinc3 outputs before settled
	localparam logic [2:0] SINC5_FILL = 3'h4;
	localparam logic [2:0] SINC3_FILL = 3'h2;
	// sinc1 length at and above which the combined path settles in one cycle
	localparam logic [11:0] SINGLE_CYCLE_LEN = 12'h00C;
	// apb register byte offsets
	localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
	localparam logic [7:0] FILTER_STATUS_OFS = 8'h04;
	localparam logic [7:0] RESULT_LO_OFS = 8'h08;
	localparam logic [7:0] RESULT_HI_OFS = 8'h0C;
	localparam logic [7:0] FILTER_CONFIG_BASE = 8'h20;
	// field positions
	localparam int unsigned MODE_SETTLED_BIT = 0;
	localparam int unsigned CFG_MAP_BIT = 15;
	localparam int unsigned CFG_RATE_LSB = 0;
	localparam int unsigned CFG_RATE_W = 4;
	localparam int unsigned CFG_TYPE_BIT = 5;
	localparam int unsigned CFG_ENH_EN_BIT = 11;
	localparam int unsigned CFG_ENH_LSB = 8;
	localparam int unsigned CFG_ENH_W = 2;
	localparam int unsigned STAT_SETUP_LSB = 0;
	localparam int unsigned STAT_SO_BIT = 4;
	localparam int unsigned STAT_STATE_LSB = 8;
	localparam int unsigned STAT_COUNT_LSB = 16;
	// reset values
	localparam logic [15:0] FILTER_CONFIG_RST = 16'h0005;
	localparam logic [31:0] MODE_CTRL_RST = 32'h0000_0000;
	// sinc1 lengths in sinc5 samples (31.25 kSPS base) for each rate code
	localparam logic [11:0] RATE_LEN [0:15] = '{
		12'h001, 12'h002, 12'h004, 12'h006, 12'h00C, 12'h019, 12'h032, 12'h064,
		12'h0FA, 12'h1F4, 12'h271, 12'h3E8, 12'h4E2, 12'h5DC, 12'h9C4, 12'hC35};
	// enhanced 50/60 Hz post-filter lengths: 27.27, 25, 20, 16.667 SPS
	localparam logic [11:0] ENH_LEN [0:3] = '{12'h47A, 12'h4E2, 12'h61A, 12'h753};
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_RUN = 2'b10
	} conv_state_t;
endpackage

// ==== verification/sdf_filter_chk_sva.sv ====
// assertions on the filter chain's bus, tick and result ports
`timescale 1ns/10ps
module sdf_filter_chk import sdf_pkg::*; #(
	parameter int unsigned MCLK_HZ = MCLK_NOMINAL_HZ
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic MOD_TICK_OUT,
	input wire logic CONV_START_IN,
	input wire logic [SETUP_W-1:0] SETUP_SEL_IN,
	input wire logic DATA_READY_OUT,
	input wire logic [RESULT_W-1:0] RESULT_OUT,
	input wire logic [SETUP_W-1:0] RESULT_SETUP_OUT
);
	localparam int TICK_DIV = 125000000 / (MCLK_HZ / 2);
	// shortest legal output period is 32 ticks; one tick of slack for start phase
	localparam int MIN_GAP = 31 * TICK_DIV;
	logic acc;
	logic [SETUP_W-1:0] setup_q;
	logic [19:0] since_q;
	assign acc = PSEL_IN && PENABLE_IN;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			setup_q <= '0;
		end else if (CONV_START_IN) begin
			setup_q <= SETUP_SEL_IN;
		end
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			since_q <= '0;
		end else if (CONV_START_IN || DATA_READY_OUT) begin
			since_q <= '0;
		end else if (since_q != 20'hF_FFFF) begin
			since_q <= since_q + 20'h0_0001;
		end
	end
	a_bus_ready: assert property (PREADY_OUT)
		else $error("bus not ready");
	a_unmapped_err: assert property (acc && PADDR_IN inside {8'h10, 8'h18, 8'h40}
		|-> PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_config_ok: assert property (acc && PADDR_IN[7:5] == 3'h1 && PADDR_IN[1:0] == 2'h0
		|-> !PSLVERR_OUT)
		else $error("config access refused");
	a_tick_period: assert property (MOD_TICK_OUT |=> !MOD_TICK_OUT ##(TICK_DIV - 1) MOD_TICK_OUT)
		else $error("modulator tick period wrong");
	a_ready_single: assert property (DATA_READY_OUT |=> !DATA_READY_OUT)
		else $error("ready wider than one cycle");
	a_result_hold: assert property (!DATA_READY_OUT
		|-> $stable(RESULT_OUT) && $stable(RESULT_SETUP_OUT))
		else $error("result changed without ready");
	a_ready_setup: assert property (DATA_READY_OUT |-> RESULT_SETUP_OUT == setup_q)
		else $error("result carries wrong setup");
	a_start_quiet: assert property (CONV_START_IN |=> !DATA_READY_OUT [*8])
		else $error("ready right after restart");
	a_ready_gap: assert property (DATA_READY_OUT |-> since_q >= MIN_GAP)
		else $error("output period too short");
	c_ready: cover property (DATA_READY_OUT);
	c_refused: cover property (acc && PSLVERR_OUT);
	c_restart: cover property (CONV_START_IN ##1 !CONV_START_IN);
endmodule // sdf_filter_chk
bind sdf_filter sdf_filter_chk #(.MCLK_HZ(MCLK_HZ)) u_chk (.CLK_SYS_IN(CLK_SYS_IN),
	.RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.MOD_TICK_OUT(MOD_TICK_OUT), .CONV_START_IN(CONV_START_IN), .SETUP_SEL_IN(SETUP_SEL_IN),
	.DATA_READY_OUT(DATA_READY_OUT), .RESULT_OUT(RESULT_OUT),
	.RESULT_SETUP_OUT(RESULT_SETUP_OUT));

// ==== verification/sdf_mod_model.sv ====
// modulator bitstream model: alternating or all-ones bits paced by the tick
`timescale 1ns/10ps
module sdf_mod_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic tick_in,
	input wire logic ones_in,
	output logic bit_out
);
	// new bit just after each tick so it is steady at the next sampling tick
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bit_out <= 1'b0;
		end else if (tick_in) begin
			bit_out <= ones_in ? 1'b1 : !bit_out;
		end
	end
endmodule // sdf_mod_model

// ==== verification/tb_top.sv ====
// self-checking bench for the decimation filter chain
`timescale 1ns/10ps
module tb_top import sdf_pkg::*;;
	localparam int unsigned MCLK = 125_000_000;
	// fast master clock: a modulator tick every second cycle keeps the run short
	localparam int DIV = 2;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic conv = 1'b0;
	logic multi = 1'b0;
	logic ones = 1'b0;
	logic [SETUP_W-1:0] sel = '0;
	logic [31:0] prdata;
	logic pready, pslverr, mod_bit, mod_tick, ready;
	logic [SETUP_W-1:0] rsetup;
	logic [RESULT_W-1:0] result;
	int n_errors = 0;
	int total_checks = 0;
	always #4 clk = ~clk;
	sdf_filter #(.MCLK_HZ(MCLK)) dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.MOD_BIT_IN(mod_bit), .MOD_TICK_OUT(mod_tick), .CONV_START_IN(conv),
		.SETUP_SEL_IN(sel), .MULTI_CHANNEL_IN(multi), .DATA_READY_OUT(ready),
		.RESULT_OUT(result), .RESULT_SETUP_OUT(rsetup));
	sdf_mod_model u_mod (.clk_in(clk), .rst_b_in(rst_b), .tick_in(mod_tick),
		.ones_in(ones), .bit_out(mod_bit));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk(64'(e), 64'h0, "write refused");
	endtask
	task automatic start(input int s);
		@(posedge clk);
		conv <= 1'b1;
		sel <= SETUP_W'(s);
		@(posedge clk);
		conv <= 1'b0;
	endtask
	// cycles between the next two ready pulses, or from the current one
	task automatic gap(output int n);
		n = 0;
		@(negedge clk);
		while (ready !== 1'b1) @(negedge clk);
		do begin
			@(negedge clk);
			n++;
		end while (ready !== 1'b1);
	endtask
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		apb(1'b0, FILTER_CONFIG_BASE, 32'h0000_0000, r, e);
		chk(64'(r), 64'(FILTER_CONFIG_RST), "config reset");
		apb(1'b0, MODE_CTRL_OFS, 32'h0000_0000, r, e);
		chk(64'(r), 64'(MODE_CTRL_RST), "mode reset");
		apb(1'b1, 8'h10, 32'h1234_5678, r, e);
		chk(64'(e), 64'h1, "unmapped write");
		apb(1'b0, 8'h10, 32'h0000_0000, r, e);
		chk({31'h0, e, r}, {31'h0, 1'b1, 32'h0}, "unmapped read");
		wr(FILTER_CONFIG_BASE + 8'h04, 32'h0000_8001);
		apb(1'b0, FILTER_CONFIG_BASE + 8'h04, 32'h0000_0000, r, e);
		chk(64'(r), 64'h8001, "config readback");
	endtask
	task automatic t_rates();
		logic [15:0] cfg [6] = '{16'h8001, 16'h8005, 16'h0020, 16'h0820, 16'h0000, 16'h0002};
		int ticks [6] = '{32, 160, 32, 32, 32, 128};
		int n;
		for (int i = 0; i < 6; i++) begin
			wr(FILTER_CONFIG_BASE + 8'(4 * i), {16'h0000, cfg[i]});
			start(i);
			gap(n);
			chk(64'(n), 64'(ticks[i] * DIV), "output period");
			chk(64'(rsetup), 64'(i), "result setup");
		end
	endtask
	task automatic t_settled();
		int n;
		wr(MODE_CTRL_OFS, 32'h0000_0001);
		ones <= 1'b1;
		wr(FILTER_CONFIG_BASE + 8'h04, 32'h0000_8001);
		start(1);
		gap(n);
		// three sinc3 periods plus the restart and clear cycles between results
		chk(64'(n), 64'(96 * DIV + 2), "settled period");
		chk(result, 64'h0000_0000_0000_8000, "settled value");
		multi <= 1'b1;
		start(1);
		gap(n);
		chk(64'(n), 64'(32 * DIV), "multi-channel period");
		multi <= 1'b0;
		wr(FILTER_CONFIG_BASE + 8'h08, 32'h0000_0004);
		start(2);
		gap(n);
		chk(64'(n), 64'(384 * DIV), "single-cycle rate period");
		wr(MODE_CTRL_OFS, 32'h0000_0000);
	endtask
	task automatic t_step();
		int n;
		ones <= 1'b0;
		start(1);
		gap(n);
		gap(n);
		ones <= 1'b1;
		gap(n);
		total_checks++;
		if (result === 64'h0000_0000_0000_8000) begin
			n_errors++;
			$display("BAD %0t settled one output after step", $time);
		end
		repeat (3) gap(n);
		chk(result, 64'h0000_0000_0000_8000, "value after step");
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_rates();
		t_settled();
		t_step();
		stop_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		stop_test();
	end
endmodule // tb_top
